/* File: common/link_bit_if.sv */
// Carries each serial bit sampled on the serial clock, with a toggle marking it.
// The toggle is the only signal that the system side may synchronise.
`timescale 1ns/1ps
`default_nettype none
interface link_bit_if;
   logic bit_val;
   logic bit_tog;
   modport capture (output bit_val, output bit_tog);
   modport consume (input bit_val, input bit_tog);
endinterface
`default_nettype wire

/* File: common/pmic_defs.svh */
// Register map, field positions, reset values and code tables for the power manager
// register logic. Definitions only; included by the register module and the bench.
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH

// Register index, taken from the low three bits of the register address byte
`define REG_ENABLE 3'h0
`define REG_STATUS 3'h1
`define REG_BUCK 3'h2
`define REG_LIN_A 3'h3
`define REG_LIN_B 3'h4

// Status register fields
`define STAT_BUCK_VALID 0
`define STAT_LIN_A_VALID 1
`define STAT_LIN_B_VALID 2
`define STAT_THERM 4
`define STAT_UV 5
`define STAT_INT_EN 6

`define STATUS_RESET 8'h00
`define VCODE_RESET 8'h00
`define TARGET_ADDR 7'h5a

// Buck code table: fine steps then coarse steps
`define BUCK_FINE_LAST 8'h0f
`define BUCK_COARSE_FIRST 8'h10
`define BUCK_COARSE_LAST 8'h1c
`define BUCK_BASE_MV 12'h320
`define BUCK_COARSE_BASE_MV 12'h4b0
`define BUCK_FINE_STEP_MV 12'h019
`define BUCK_COARSE_STEP_MV 12'h032

// Linear regulator table: entry i gives base + i * step
`define LIN_BASE_MV 12'h320
`define LIN_STEP_MV 12'h032
`define LIN_TABLE_LEN 51
`define LIN_CODES '{8'h00, 8'h0b, 8'h14, 8'h1d, 8'h25, 8'h2e, 8'h37, 8'h3e, 8'h45, 8'h4c, \
   8'h52, 8'h57, 8'h5c, 8'h61, 8'h65, 8'h69, 8'h6d, 8'h72, 8'h79, 8'h7f, 8'h85, 8'h8b, \
   8'h91, 8'h96, 8'h9a, 8'h9f, 8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb7, 8'hba, 8'hbd, \
   8'hc1, 8'hc4, 8'hc7, 8'hc9, 8'hcc, 8'hce, 8'hd1, 8'hd3, 8'hd6, 8'hd8, 8'hda, 8'hdc, \
   8'hde, 8'he1, 8'he3, 8'he6, 8'he8}

`endif

/* File: common/pmic_pkg.sv */
// Types shared by the power manager register logic.
// Assumes pmic_defs.svh is on the include path.
package pmic_pkg;
   typedef logic [7:0] code_t;
   typedef logic [11:0] mv_t;

   typedef struct packed {
      logic ok;
      mv_t mv;
   } volt_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ACK_ADDR = 4'b0010,
      ST_REG = 4'b0011,
      ST_ACK_REG = 4'b0100,
      ST_WDATA = 4'b0101,
      ST_ACK_WDATA = 4'b0110,
      ST_RDATA = 4'b0111,
      ST_RACK = 4'b1000
   } serial_state_e;
endpackage

/* File: dv/i2c_host_model.sv */
// I2C host model: drives the serial clock and pulls the data line low as an open-drain master.
// Assumes the bench resolves the data line with a pull-up from every party's pull-down.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_defs.svh"
module i2c_host_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   logic lk = 1'b0;

   // The serial clock stands high and still outside frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      #1.3;
      forever #7.5 lk = ~lk;
   end

   // 45 ns half periods keep the device's synchronised copy of the clock from missing edges
   task automatic hp();
      repeat (3) @(posedge lk);
   endtask

   task automatic bit_io(input logic b, output logic r);
      @(posedge lk);
      sda_low = !b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      scl = 1'b0;
   endtask

   task automatic start();
      @(posedge lk);
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b1;
      hp();
      scl = 1'b0;
   endtask

   task automatic stop();
      @(posedge lk);
      sda_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b0;
      hp();
   endtask

   // Ninth bit is always released: the device acks writes, the host nacks read data
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask

   task automatic wr(input logic [6:0] ta, input logic [7:0] ra, input logic [7:0] d,
         output logic ok);
      logic [7:0] q;
      logic a1, a2, a3;
      start();
      byte_io({ta, 1'b0}, q, a1);
      byte_io(ra, q, a2);
      byte_io(d, q, a3);
      stop();
      ok = a1 & a2 & a3;
   endtask

   task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a1, a2, a3, a4;
      start();
      byte_io({`TARGET_ADDR, 1'b0}, q, a1);
      byte_io(ra, q, a2);
      start();
      byte_io({`TARGET_ADDR, 1'b1}, q, a3);
      byte_io(8'hff, d, a4);
      stop();
      ok = a1 & a2 & a3 & !a4;
   endtask

   // Host acknowledge after the first data byte asks for the same register once more
   task automatic rd2(input logic [7:0] ra, output logic [7:0] d1, output logic [7:0] d2,
         output logic ok);
      logic [7:0] q;
      logic a1, a2, a3, a4, r;
      start();
      byte_io({`TARGET_ADDR, 1'b0}, q, a1);
      byte_io(ra, q, a2);
      start();
      byte_io({`TARGET_ADDR, 1'b1}, q, a3);
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d1[i] = r;
      end
      bit_io(1'b0, r);
      byte_io(8'hff, d2, a4);
      stop();
      ok = a1 & a2 & a3 & !a4;
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Bench for the power manager register logic: the host model writes and reads registers
// while a behavioural model predicts every code output, decoded voltage and read byte.
// Assumes pmic_defs.svh on the include path and i2c_host_model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_defs.svh"
module tb
   import pmic_pkg::*;
   ;
   logic sys_clk, rst, startup, uv_c, th_c, ok, m_uv, m_th, m_ie;
   logic [2:0] vin;
   logic [7:0] rd_a, rd_b;
   logic [7:0] m_reg [0:7];
   logic [7:0] lin_tab [0:50] = `LIN_CODES;
   logic [31:0] seed = 32'h0000004e;
   int mismatches = 0;
   int n_compared = 0;
   wire logic scl, h_low, sda_w, sda_oe, sda_o, irq_i, irq_oe, irq_o, launch;
   wire code_t code [2:4];
   wire mv_t mv [2:4];
   wire logic mv_ok [2:4];

   assign sda_w = !(h_low || (sda_oe && !sda_o));
   assign irq_i = !(irq_oe && !irq_o);

   pmic_status_voltage_regs DUT (
      .SYS_CLK(sys_clk), .RST(rst), .SCL(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .FAULT_INTERRUPT_OUT_I(irq_i), .FAULT_INTERRUPT_OUT_O(irq_o),
      .FAULT_INTERRUPT_OUT_OE(irq_oe), .STARTUP_PIN(startup), .STARTUP_LAUNCH(launch),
      .BUCK_VALID_IN(vin[0]), .LINEAR_A_VALID_IN(vin[1]), .LINEAR_B_VALID_IN(vin[2]),
      .INPUT_UNDERVOLTAGE_COND(uv_c), .THERMAL_SHUTDOWN_COND(th_c),
      .BUCK_CODE(code[2]), .LINEAR_A_CODE(code[3]), .LINEAR_B_CODE(code[4]),
      .BUCK_MV(mv[2]), .BUCK_MV_OK(mv_ok[2]), .LINEAR_A_MV(mv[3]),
      .LINEAR_A_MV_OK(mv_ok[3]), .LINEAR_B_MV(mv[4]), .LINEAR_B_MV_OK(mv_ok[4])
   );

   i2c_host_model host (.scl(scl), .sda_low(h_low), .sda(sda_w));

   // Flags are sticky in the model too: any cycle of live condition sets them
   always @(posedge sys_clk) begin
      if (uv_c) m_uv <= 1'b1;
      if (th_c) m_th <= 1'b1;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [12:0] exp_buck(input logic [7:0] c);
      if (c <= 8'h0f) return {1'b1, 12'(800 + 25 * c)};
      if (c <= 8'h1c) return {1'b1, 12'(1200 + 50 * (c - 16))};
      return 13'h0000;
   endfunction

   function automatic logic [12:0] exp_lin(input logic [7:0] c);
      for (int i = 0; i < 51; i++)
         if (lin_tab[i] === c) return {1'b1, 12'(800 + 50 * i)};
      return 13'h0000;
   endfunction

   function automatic logic [7:0] exp_rd(input logic [2:0] i);
      if (i == `REG_STATUS) return {1'b0, m_ie, m_uv, m_th, 1'b0, vin};
      if (i inside {`REG_BUCK, `REG_LIN_A, `REG_LIN_B}) return m_reg[i];
      return 8'h00;
   endfunction

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp(input logic [12:0] g, input logic [12:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic cmp_byte(input code_t g, input code_t e);
      cmp({5'h00, g}, {5'h00, e});
   endtask

   task automatic cmp_volt(input logic [12:0] g, input logic [12:0] e);
      cmp(g, e);
   endtask

   task automatic cmp_bit(input logic g, input logic e);
      cmp({12'h000, g}, {12'h000, e});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic check_codes();
      for (int i = 2; i <= 4; i++) begin
         cmp_byte(code[i], m_reg[i]);
         cmp_volt({mv_ok[i], mv[i]}, (i == 2) ? exp_buck(m_reg[i]) : exp_lin(m_reg[i]));
      end
   endtask

   task automatic wreg(input logic [7:0] ra, input logic [7:0] d);
      logic a;
      host.wr(`TARGET_ADDR, ra, d, a);
      cmp_bit(a, 1'b1);
      if (ra[2:0] == `REG_STATUS) begin
         m_ie = d[6];
         m_uv = (m_uv & !d[5]) | uv_c;
         m_th = (m_th & !d[4]) | th_c;
      end else if (ra[2:0] inside {`REG_BUCK, `REG_LIN_A, `REG_LIN_B}) begin
         m_reg[ra[2:0]] = d;
      end
      check_codes();
   endtask

   task automatic rreg(input logic [7:0] ra);
      logic [7:0] d;
      logic a;
      host.rd(ra, d, a);
      cmp_bit(a, 1'b1);
      cmp_byte(d, exp_rd(ra[2:0]));
   endtask

   task automatic wait_irq(input logic v);
      for (int n = 0; n < 20 && irq_oe !== v; n++) tick(1);
      cmp_bit(irq_oe, v);
   endtask

   task automatic pin(input logic v, input int exp);
      int n;
      n = 0;
      tick(1);
      startup = v;
      for (int k = 0; k < 12; k++) begin
         tick(1);
         if (launch === 1'b1) n++;
      end
      cmp_byte(8'(n), 8'(exp));
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      #500us;
      mismatches++;
      results();
   end

   initial begin
      rst = 1'b1;
      startup = 1'b0;
      uv_c = 1'b0;
      th_c = 1'b0;
      vin = 3'h0;
      m_uv = 1'b0;
      m_th = 1'b0;
      m_ie = 1'b0;
      for (int i = 0; i < 8; i++) m_reg[i] = 8'h00;
      tick(6);
      rst = 1'b0;
      tick(5);
      check_codes();
      rreg(8'h01);
      for (int i = 0; i < 3; i++) begin
         vin = 3'(rnd());
         tick(4);
         rreg(8'h01);
      end
      for (int c = 0; c <= 28; c++) wreg(8'h02, 8'(c));
      wreg(8'h02, 8'h80 | 8'(rnd()));
      rreg(8'h02);
      for (int i = 0; i < 51; i++) wreg(8'h03 + 8'(i % 2), lin_tab[i]);
      wreg(8'h03, 8'(rnd()));
      rreg(8'h03);
      host.rd2(8'h03, rd_a, rd_b, ok);
      cmp_bit(ok, 1'b1);
      cmp_byte(rd_a, m_reg[3]);
      cmp_byte(rd_b, m_reg[3]);
      wreg(8'h04, 8'h01);
      rreg(8'h04);
      wreg(8'hfa, 8'h07);
      rreg(8'h0a);
      wreg(8'h05, 8'h5a);
      rreg(8'h05);
      host.wr(`TARGET_ADDR ^ 7'h01, 8'h02, 8'h33, ok);
      cmp_bit(ok, 1'b0);
      check_codes();
      wreg(8'h01, 8'h8f);
      rreg(8'h01);
      uv_c = 1'b1;
      tick(6);
      uv_c = 1'b0;
      rreg(8'h01);
      rreg(8'h01);
      wreg(8'h01, 8'h00);
      rreg(8'h01);
      wreg(8'h01, 8'h20);
      rreg(8'h01);
      th_c = 1'b1;
      tick(6);
      wreg(8'h01, 8'h10);
      rreg(8'h01);
      wreg(8'h01, 8'h40);
      rreg(8'h01);
      wait_irq(1'b1);
      cmp_bit(irq_o, 1'b0);
      th_c = 1'b0;
      wait_irq(1'b0);
      uv_c = 1'b1;
      th_c = 1'b1;
      wait_irq(1'b1);
      wreg(8'h01, 8'h30);
      wait_irq(1'b0);
      rreg(8'h01);
      uv_c = 1'b0;
      th_c = 1'b0;
      tick(6);
      wreg(8'h01, 8'h30);
      rreg(8'h01);
      pin(1'b1, 1);
      pin(1'b1, 0);
      pin(1'b0, 0);
      pin(1'b1, 1);
      results();
   end
endmodule
`default_nettype wire

/* File: logic/pmic_status_voltage_regs.sv */
// Serial-port register logic of a three-output power manager: status and fault flags,
// voltage code registers with table decode, interrupt drive and startup-pin edge detect.
// Assumes SYS_CLK far faster than the serial clock; analog inputs arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_defs.svh"

module pmic_status_voltage_regs
   import pmic_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic FAULT_INTERRUPT_OUT_I,
   output logic FAULT_INTERRUPT_OUT_O,
   output logic FAULT_INTERRUPT_OUT_OE,
   input wire logic STARTUP_PIN,
   output logic STARTUP_LAUNCH,
   input wire logic BUCK_VALID_IN,
   input wire logic LINEAR_A_VALID_IN,
   input wire logic LINEAR_B_VALID_IN,
   input wire logic INPUT_UNDERVOLTAGE_COND,
   input wire logic THERMAL_SHUTDOWN_COND,
   output logic [7:0] BUCK_CODE,
   output logic [7:0] LINEAR_A_CODE,
   output logic [7:0] LINEAR_B_CODE,
   output logic [11:0] BUCK_MV,
   output logic BUCK_MV_OK,
   output logic [11:0] LINEAR_A_MV,
   output logic LINEAR_A_MV_OK,
   output logic [11:0] LINEAR_B_MV,
   output logic LINEAR_B_MV_OK
);
   localparam code_t LIN_CODE_TAB [`LIN_TABLE_LEN] = `LIN_CODES;

   link_bit_if lk ();

   logic [8:0] raw_in;
   logic [8:0] syn_q;
   logic scl_s, sda_s, en_s, tog_s, uv_cond_s, th_cond_s;
   logic [2:0] vld_s;
   logic scl_d_r, sda_d_r, en_d_r, tog_d_r;
   logic [1:0] arm_r;
   logic start_ev, stop_ev, scl_fall, bit_ev, bit_in, last_bit, in_ack, load_rd;
   serial_state_e st_r, st_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, byte_nxt, rd_word, status_word;
   logic rw_r;
   logic [2:0] reg_addr_r;
   logic wr_en, wr_status, wr_buck, wr_lin_a, wr_lin_b;
   logic [7:0] wdata;
   logic sda_oe_r, drive_nxt;
   logic uv_flag_r, th_flag_r, int_en_r;
   logic uv_flag_nxt, th_flag_nxt;
   logic [7:0] buck_code_r, lin_a_code_r, lin_b_code_r;
   volt_s buck_dec, lin_a_dec, lin_b_dec;
   logic launch_r;
   logic irq_act;

   function automatic volt_s buck_decode(input code_t code);
      volt_s v;
      v.ok = 1'b1;
      if (code <= `BUCK_FINE_LAST) begin
         v.mv = `BUCK_BASE_MV + 12'(code) * `BUCK_FINE_STEP_MV;
      end else if (code <= `BUCK_COARSE_LAST) begin
         v.mv = `BUCK_COARSE_BASE_MV + 12'(code - `BUCK_COARSE_FIRST) * `BUCK_COARSE_STEP_MV;
      end else begin
         // Codes past the table leave the regulator setting undefined
         v.ok = 1'b0;
         v.mv = 12'h000;
      end
      return v;
   endfunction

   function automatic volt_s lin_decode(input code_t code);
      volt_s v;
      v.ok = 1'b0;
      v.mv = 12'h000;
      for (int i = 0; i < `LIN_TABLE_LEN; i++) begin
         if (code == LIN_CODE_TAB[i]) begin
            v.ok = 1'b1;
            v.mv = `LIN_BASE_MV + 12'(i) * `LIN_STEP_MV;
         end
      end
      return v;
   endfunction

   scl_bit_capture u_capture (
      .scl_clk(SCL),
      .rst(RST),
      .sda_in(SDA_I),
      .lk(lk.capture)
   );

   assign raw_in = {lk.bit_tog, THERMAL_SHUTDOWN_COND, INPUT_UNDERVOLTAGE_COND,
                    LINEAR_B_VALID_IN, LINEAR_A_VALID_IN, BUCK_VALID_IN,
                    STARTUP_PIN, SDA_I, SCL};

   sync2 #(.W(9)) u_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .d(raw_in),
      .q(syn_q)
   );

   assign scl_s = syn_q[0];
   assign sda_s = syn_q[1];
   assign en_s = syn_q[2];
   assign vld_s = syn_q[5:3];
   assign uv_cond_s = syn_q[6];
   assign th_cond_s = syn_q[7];
   assign tog_s = syn_q[8];

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         scl_d_r <= 1'b0;
         sda_d_r <= 1'b0;
         en_d_r <= 1'b1;
         tog_d_r <= 1'b0;
         arm_r <= 2'h0;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         // Until the synchroniser has filled, a pin already high must not look like an edge
         en_d_r <= arm_r[1] ? en_s : 1'b1;
         tog_d_r <= tog_s;
         arm_r <= {arm_r[0], 1'b1};
      end
   end

   // Bus conditions seen at the synchronised pins; data bits come from the serial domain
   assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign scl_fall = scl_d_r & ~scl_s;
   assign bit_ev = tog_s ^ tog_d_r;
   // Held stable by the serial domain for a whole serial clock period after the toggle
   assign bit_in = lk.bit_val;
   assign byte_nxt = {sh_r[6:0], bit_in};
   assign last_bit = bit_ev & (cnt_r == 3'h7);
   assign in_ack = (st_r == ST_ACK_ADDR) | (st_r == ST_ACK_REG) |
                   (st_r == ST_ACK_WDATA) | (st_r == ST_RACK);

   always_comb begin
      st_nxt = st_r;
      if (stop_ev) begin
         st_nxt = ST_IDLE;
      end else if (start_ev) begin
         st_nxt = ST_ADDR;
      end else if (bit_ev) begin
         case (st_r)
            ST_IDLE: st_nxt = ST_IDLE;
            ST_ADDR: begin
               if (cnt_r == 3'h7) begin
                  st_nxt = (byte_nxt[7:1] == `TARGET_ADDR) ? ST_ACK_ADDR : ST_IDLE;
               end
            end
            ST_ACK_ADDR: st_nxt = rw_r ? ST_RDATA : ST_REG;
            ST_REG: begin
               if (cnt_r == 3'h7) begin
                  st_nxt = ST_ACK_REG;
               end
            end
            ST_ACK_REG: st_nxt = ST_WDATA;
            ST_WDATA: begin
               if (cnt_r == 3'h7) begin
                  st_nxt = ST_ACK_WDATA;
               end
            end
            ST_ACK_WDATA: st_nxt = ST_WDATA;
            ST_RDATA: begin
               if (cnt_r == 3'h7) begin
                  st_nxt = ST_RACK;
               end
            end
            // Host acknowledge rereads the same register; no acknowledge ends the read
            ST_RACK: st_nxt = bit_in ? ST_IDLE : ST_RDATA;
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   assign cnt_nxt = start_ev ? 3'h0 : (bit_ev ? (in_ack ? 3'h0 : cnt_r + 3'h1) : cnt_r);
   assign load_rd = bit_ev & (st_nxt == ST_RDATA) & (st_r != ST_RDATA);
   assign sh_nxt = load_rd ? rd_word : (bit_ev ? byte_nxt : sh_r);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         st_r <= ST_IDLE;
         cnt_r <= 3'h0;
         sh_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rw_r <= 1'b0;
         reg_addr_r <= 3'h0;
      end else begin
         if (last_bit && st_r == ST_ADDR) begin
            rw_r <= byte_nxt[0];
         end
         if (last_bit && st_r == ST_REG) begin
            reg_addr_r <= byte_nxt[2:0];
         end
      end
   end

   // Data line changes after the serial clock has fallen, or is released at a start or stop
   assign drive_nxt = (st_r == ST_ACK_ADDR) | (st_r == ST_ACK_REG) |
                      (st_r == ST_ACK_WDATA) | ((st_r == ST_RDATA) & ~sh_r[7]);

   always_ff @(posedge SYS_CLK) begin
      if (RST || start_ev || stop_ev) begin
         sda_oe_r <= 1'b0;
      end else if (scl_fall) begin
         sda_oe_r <= drive_nxt;
      end
   end

   assign SDA_O = 1'b0;
   assign SDA_OE = sda_oe_r;

   assign wr_en = last_bit & (st_r == ST_WDATA);
   assign wdata = byte_nxt;
   assign wr_status = wr_en & (reg_addr_r == `REG_STATUS);
   assign wr_buck = wr_en & (reg_addr_r == `REG_BUCK);
   assign wr_lin_a = wr_en & (reg_addr_r == `REG_LIN_A);
   assign wr_lin_b = wr_en & (reg_addr_r == `REG_LIN_B);

   // A fault present in the clearing cycle keeps its flag: set beats clear
   assign uv_flag_nxt = uv_cond_s | (uv_flag_r & ~(wr_status & wdata[`STAT_UV]));
   assign th_flag_nxt = th_cond_s | (th_flag_r & ~(wr_status & wdata[`STAT_THERM]));

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         uv_flag_r <= 1'(`STATUS_RESET >> `STAT_UV);
         th_flag_r <= 1'b0;
         int_en_r <= 1'b0;
      end else begin
         uv_flag_r <= uv_flag_nxt;
         th_flag_r <= th_flag_nxt;
         if (wr_status) begin
            int_en_r <= wdata[`STAT_INT_EN];
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         buck_code_r <= `VCODE_RESET;
         lin_a_code_r <= `VCODE_RESET;
         lin_b_code_r <= `VCODE_RESET;
      end else begin
         if (wr_buck) begin
            buck_code_r <= wdata;
         end
         if (wr_lin_a) begin
            lin_a_code_r <= wdata;
         end
         if (wr_lin_b) begin
            lin_b_code_r <= wdata;
         end
      end
   end

   assign status_word = {1'b0, int_en_r, uv_flag_r, th_flag_r, 1'b0, vld_s};
   // Enable register lives elsewhere, so index 0 and unused indices read zero
   assign rd_word = (reg_addr_r == `REG_STATUS) ? status_word :
                    (reg_addr_r == `REG_BUCK) ? buck_code_r :
                    (reg_addr_r == `REG_LIN_A) ? lin_a_code_r :
                    (reg_addr_r == `REG_LIN_B) ? lin_b_code_r : 8'h00;

   assign buck_dec = buck_decode(buck_code_r);
   assign lin_a_dec = lin_decode(lin_a_code_r);
   assign lin_b_dec = lin_decode(lin_b_code_r);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         {BUCK_MV_OK, BUCK_MV} <= 13'h0000;
         {LINEAR_A_MV_OK, LINEAR_A_MV} <= 13'h0000;
         {LINEAR_B_MV_OK, LINEAR_B_MV} <= 13'h0000;
      end else begin
         {BUCK_MV_OK, BUCK_MV} <= buck_dec;
         {LINEAR_A_MV_OK, LINEAR_A_MV} <= lin_a_dec;
         {LINEAR_B_MV_OK, LINEAR_B_MV} <= lin_b_dec;
      end
   end

   assign BUCK_CODE = buck_code_r;
   assign LINEAR_A_CODE = lin_a_code_r;
   assign LINEAR_B_CODE = lin_b_code_r;

   // Only a rising edge launches; a pin held high after reset does nothing
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         launch_r <= 1'b0;
      end else begin
         launch_r <= en_s & ~en_d_r;
      end
   end

   assign STARTUP_LAUNCH = launch_r;

   // Follows the live fault, not the sticky flag, so it drops when the fault goes
   assign irq_act = int_en_r & (uv_cond_s | th_cond_s);
   assign FAULT_INTERRUPT_OUT_O = 1'b0;
   assign FAULT_INTERRUPT_OUT_OE = irq_act;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   chk_valid_shown:
   assert property (BUCK_VALID_IN [*3] |-> status_word[`STAT_BUCK_VALID])
      else $error("buck valid input not shown in status");

   chk_fault_sets:
   assert property (uv_cond_s |=> uv_flag_r ##1
                    (uv_flag_r || $past(wr_status && wdata[`STAT_UV])))
      else $error("undervoltage flag not set by fault");

   chk_flag_sticky:
   assert property (th_flag_r && !(wr_status && wdata[`STAT_THERM]) |=> th_flag_r)
      else $error("thermal flag dropped without a clear");

   chk_echo_clear:
   assert property (wr_status && wdata[`STAT_UV] && !uv_cond_s |=> !uv_flag_r)
      else $error("writing one did not clear undervoltage flag");

   chk_reset_persist:
   assert property (wr_status && wdata[`STAT_THERM] && th_cond_s |=> th_flag_r)
      else $error("persisting fault lost its flag on clear");

   chk_int_enable:
   assert property (wr_status |=> int_en_r == $past(wdata[`STAT_INT_EN]))
      else $error("interrupt enable not written");

   chk_irq_follow:
   assert property (int_en_r && $rose(th_cond_s) |-> FAULT_INTERRUPT_OUT_OE ##1 th_flag_r)
      else $error("interrupt not asserted with fault");

   chk_buck_decode:
   assert property (wr_buck && wdata == 8'h1c |-> ##2 BUCK_MV_OK && BUCK_MV == 12'h708)
      else $error("buck top code not decoded to 1800 mV");

   chk_lin_decode:
   assert property (wr_lin_a && wdata == 8'he8 |-> ##2 LINEAR_A_MV_OK && LINEAR_A_MV == 12'hce4)
      else $error("linear top code not decoded to 3300 mV");

   chk_raw_store:
   assert property (wr_lin_b |=> lin_b_code_r == $past(wdata) ##1
                    lin_b_code_r == $past(wdata, 2))
      else $error("linear B code not stored as written");

   chk_addr_reject:
   assert property (last_bit && st_r == ST_ADDR && byte_nxt[7:1] != `TARGET_ADDR
                    && !start_ev && !stop_ev |=> st_r == ST_IDLE ##1 !SDA_OE)
      else $error("foreign target address accepted");

   chk_edge_only:
   assert property (STARTUP_LAUNCH |=> !STARTUP_LAUNCH [*2])
      else $error("startup launched by a steady level");
endmodule
`default_nettype wire

/* File: logic/scl_bit_capture.sv */
// Serial clock domain front end: samples the data line on each rising serial clock edge.
// Assumes the host meets data setup to the rising edge, so the raw line is safe here.
`timescale 1ns/1ps
`default_nettype none
module scl_bit_capture (
   input wire logic scl_clk,
   input wire logic rst,
   input wire logic sda_in,
   link_bit_if.capture lk
);
   // Serial clock may stand still during reset, so this reset acts without it
   always_ff @(posedge scl_clk or posedge rst) begin
      if (rst) begin
         lk.bit_val <= 1'b0;
         lk.bit_tog <= 1'b0;
      end else begin
         lk.bit_val <= sda_in;
         lk.bit_tog <= ~lk.bit_tog;
      end
   end
endmodule
`default_nettype wire

/* File: logic/sync2.sv */
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit changes slowly enough that bits need not stay coherent.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire
